// >>> rtl/sci_pkg.sv
package sci_pkg;

  // register byte offsets
  localparam logic [11:0] SCI_OFF_PORT_RST = 12'h048;
  localparam logic [11:0] SCI_OFF_RAW      = 12'h050;
  localparam logic [11:0] SCI_OFF_MASK     = 12'h054;
  localparam logic [11:0] SCI_OFF_MSTAT    = 12'h058;
  localparam logic [11:0] SCI_OFF_BORCTL   = 12'h060;
  localparam logic [11:0] SCI_OFF_CAPS     = 12'h064;

  localparam int unsigned SCI_ADDR_W  = 12;
  localparam int unsigned SCI_DATA_W  = 32;
  localparam int unsigned SCI_PORT_W  = 5;
  localparam int unsigned SCI_NUM_EVT = 7;

  // event bit positions
  localparam int unsigned SCI_EVT_PLL_FAULT = 0;
  localparam int unsigned SCI_EVT_BROWNOUT  = 1;
  localparam int unsigned SCI_EVT_REG_UNREG = 2;
  localparam int unsigned SCI_EVT_MAIN_OSC  = 3;
  localparam int unsigned SCI_EVT_INT_OSC   = 4;
  localparam int unsigned SCI_EVT_CUR_LIM   = 5;
  localparam int unsigned SCI_EVT_PLL_LOCK  = 6;

  // brown-out control field
  localparam int unsigned SCI_BOR_SEL_BIT = 1;

  // reset values
  localparam logic [SCI_PORT_W-1:0]  SCI_PORT_RST_RST = 5'h00;
  localparam logic [SCI_NUM_EVT-1:0] SCI_MASK_RST     = 7'h00;
  localparam logic                   SCI_BOR_SEL_RST  = 1'b0;
  localparam logic                   SCI_RAW_RST      = 1'b0;

  typedef struct packed {
    logic pll_lock_raw;
    logic current_limit_raw;
    logic int_osc_fault_raw;
    logic main_osc_fault_raw;
    logic regulator_unregulated_raw;
    logic brownout_raw;
    logic pll_fault_raw;
  } sci_evt_s;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [SCI_ADDR_W-1:0] paddr;
    logic [SCI_DATA_W-1:0] pwdata;
    logic [3:0]            pstrb;
  } sci_apb_req_s;

  typedef struct packed {
    logic                  pready;
    logic                  pslverr;
    logic [SCI_DATA_W-1:0] prdata;
  } sci_apb_rsp_s;

  typedef struct packed {
    logic [SCI_PORT_W-1:0]  port_rst;
    logic [SCI_NUM_EVT-1:0] mask;
    logic                   bor_sel;
    logic                   bor_rst;
    logic                   irq;
    logic [SCI_DATA_W-1:0]  prdata;
  } sci_state_s;

  typedef struct packed {
    logic flag;
  } sci_bit_s;

endpackage

// >>> rtl/sci_event_bit.sv
`timescale 1ns/1ns
module sci_event_bit #(
  parameter logic RST_VAL = sci_pkg::SCI_RAW_RST
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);
  import sci_pkg::*;

  sci_bit_s st_q;
  sci_bit_s st_d;

  // set wins so an event on the clear cycle is kept
  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.flag = 1'b0;
    end
    if (set) begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{flag: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign flag_q = st_q.flag;

  set_wins_a: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    set |=> flag_q)
    else $error("event lost on clear cycle");

endmodule

// >>> rtl/sci_top.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
// Notes on behaviour
// [R1] port reset writes only reach bits the capabilities input reports
// [R2] five port reset bits, port A at bit 0 up to port E, reset zero
// [R3] port reset bits 31..5 read zero and ignore writes
// [R4] raw event status is read-only, set by hardware, zero after reset
// [R5] raw bit 6 set when the pll lock timer fires
// [R6] raw bit 5 set when the regulator current limit asserts
// [R7] raw bit 4 set on an internal oscillator fault
// [R8] raw bit 3 set on a main oscillator fault
// [R9] raw bit 2 set when the regulator output is unregulated
// [R10] raw bit 1 records brown-out; irq only if masked and select clear
// [R11] raw bit 0 set when the pll stops oscillating
// [R12] raw and mask bits 31..7 read zero and ignore writes
// [R13] seven mask bits aligned with raw bits, reset zero
// [R14] pll lock mask set lets pll lock raw raise the irq
// [R15] brown-out mask set lets brown-out raw raise the irq
// [R16] pll fault mask set lets pll fault raw raise the irq
// [R17] brown-out select high signals reset, low signals interrupt
// [R18] masked status reads raw and mask; write one clears raw bit; code clears only raw bits whose mask bit is set
// [R19] one level irq while any raw and mask bit is set, brown-out only while select is clear
// [R20] each port reset bit holds its port in reset while set
module sci_top #(
  parameter int unsigned NUM_PORTS = sci_pkg::SCI_PORT_W
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire sci_pkg::sci_apb_req_s           apb_req,
  output sci_pkg::sci_apb_rsp_s                apb_rsp,
  input  wire sci_pkg::sci_evt_s               evt_in,
  input  wire logic [sci_pkg::SCI_PORT_W-1:0]  device_capabilities_ports,
  output logic [sci_pkg::SCI_PORT_W-1:0]       port_reset,
  output logic                                 irq,
  output logic                                 brownout_reset_req
);
  import sci_pkg::*;

  localparam int unsigned PW = SCI_PORT_W;
  localparam int unsigned NE = SCI_NUM_EVT;

  // ports beyond NUM_PORTS never exist, whatever the straps say
  localparam logic [PW-1:0] PORT_PRESENT = PW'((1 << NUM_PORTS) - 1);

  generate
    if (NUM_PORTS < 1 || NUM_PORTS > SCI_PORT_W) begin : g_bad_ports
      $error("NUM_PORTS must lie between 1 and the port field width");
    end
  endgenerate

  sci_state_s st_q;
  sci_state_s st_d;

  logic [NE-1:0] evt_vec;
  logic [NE-1:0] raw_q;
  logic [NE-1:0] raw_clr;
  logic [NE-1:0] irq_src;
  logic [PW-1:0] wr_gate;
  logic          setup;
  logic          access;
  logic          wr_en;
  logic          hit_port;
  logic          hit_raw;
  logic          hit_mask;
  logic          hit_mstat;
  logic          hit_bor;
  logic          hit_caps;
  logic          mapped;
  logic [31:0]   rd_mux;

  assign evt_vec = evt_in;

  // bus decode
  always_comb begin
    setup     = apb_req.psel & ~apb_req.penable;
    access    = apb_req.psel & apb_req.penable;
    hit_port  = apb_req.paddr == SCI_OFF_PORT_RST;
    hit_raw   = apb_req.paddr == SCI_OFF_RAW;
    hit_mask  = apb_req.paddr == SCI_OFF_MASK;
    hit_mstat = apb_req.paddr == SCI_OFF_MSTAT;
    hit_bor   = apb_req.paddr == SCI_OFF_BORCTL;
    hit_caps  = apb_req.paddr == SCI_OFF_CAPS;
    mapped    = hit_port | hit_raw | hit_mask | hit_mstat | hit_bor
              | hit_caps;
    // all fields sit in byte lane 0, so only that strobe matters
    wr_en     = access & apb_req.pwrite & apb_req.pstrb[0] & mapped;
  end

  // [R1] capability write gate
  assign wr_gate = device_capabilities_ports & PORT_PRESENT;

  // [R18] write one clears raw where the mask bit is set
  always_comb begin
    raw_clr = '0;
    if (wr_en && hit_mstat) begin
      raw_clr = apb_req.pwdata[NE-1:0] & st_q.mask;
    end
  end

  // [R4] hardware-set sticky bits
  // [R5] one bit per event source
  // [R6] current limit event
  // [R7] internal oscillator fault
  // [R8] main oscillator fault
  // [R9] regulator unregulated event
  // [R11] pll fault event
  generate
    for (genvar i = 0; i < NE; i++) begin : g_evt
      sci_event_bit #(
        .RST_VAL (SCI_RAW_RST)
      ) u_bit (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (evt_vec[i]),
        .clr     (raw_clr[i]),
        .flag_q  (raw_q[i])
      );
    end
  endgenerate

  // read mux, evaluated in setup so data is ready in access
  // [R12] reserved bits zero
  always_comb begin
    case (apb_req.paddr)
      SCI_OFF_PORT_RST: rd_mux = 32'(st_q.port_rst);
      SCI_OFF_RAW:      rd_mux = 32'(raw_q);
      SCI_OFF_MASK:     rd_mux = 32'(st_q.mask);
      SCI_OFF_MSTAT:    rd_mux = 32'(raw_q & st_q.mask);
      SCI_OFF_BORCTL:   rd_mux = 32'(st_q.bor_sel) << SCI_BOR_SEL_BIT;
      SCI_OFF_CAPS:     rd_mux = 32'(wr_gate);
      default:          rd_mux = '0;
    endcase
  end

  // brown-out drops out of the irq once it is routed to reset
  // [R10] brown-out irq gate
  always_comb begin
    irq_src = raw_q & st_q.mask;
    if (st_q.bor_sel) begin
      irq_src[SCI_EVT_BROWNOUT] = 1'b0;
    end
  end

  always_comb begin
    st_d = st_q;
    // [R2] port reset write
    // [R3] upper bits dropped
    if (wr_en && hit_port) begin
      st_d.port_rst = (st_q.port_rst & ~wr_gate)
                    | (apb_req.pwdata[PW-1:0] & wr_gate);
    end
    // [R13] mask write
    if (wr_en && hit_mask) begin
      st_d.mask = apb_req.pwdata[NE-1:0];
    end
    if (wr_en && hit_bor) begin
      st_d.bor_sel = apb_req.pwdata[SCI_BOR_SEL_BIT];
    end
    // [R17] brown-out reset route
    st_d.bor_rst = evt_vec[SCI_EVT_BROWNOUT] & st_q.bor_sel;
    // [R19] level irq
    // [R14] masked events combine
    // [R15] brown-out mask path
    // [R16] pll fault mask path
    st_d.irq = |irq_src;
    if (setup) begin
      st_d.prdata = rd_mux;
    end else if (!access) begin
      st_d.prdata = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{port_rst: SCI_PORT_RST_RST,
                mask:     SCI_MASK_RST,
                bor_sel:  SCI_BOR_SEL_RST,
                bor_rst:  1'b0,
                irq:      1'b0,
                prdata:   '0};
    end else begin
      st_q <= st_d;
    end
  end

  // zero wait states keep the slave simple; reads stay correct
  // because data is captured in setup
  always_comb begin
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = access & ~mapped;
    apb_rsp.prdata  = st_q.prdata;
  end

  // [R20] port held in reset
  assign port_reset         = st_q.port_rst;
  assign irq                = st_q.irq;
  assign brownout_reset_req = st_q.bor_rst;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence port_wr_s;
    wr_en && hit_port;
  endsequence

  sequence mask_wr_s;
    wr_en && hit_mask;
  endsequence

  sequence mstat_wr_s;
    wr_en && hit_mstat;
  endsequence

  sequence read_acc_s;
    access && !apb_req.pwrite;
  endsequence

  caps_gate_a: assert property ( // [R1]
    port_wr_s |=> ((port_reset & ~$past(wr_gate))
                  == ($past(st_q.port_rst) & ~$past(wr_gate))))
    else $error("port reset bit written without capability");

  port_wr_a: assert property ( // [R2]
    port_wr_s |=> ((port_reset & $past(wr_gate))
                  == ($past(apb_req.pwdata[PW-1:0]) & $past(wr_gate))))
    else $error("port reset write not stored");

  port_rsvd_a: assert property ( // [R3]
    (read_acc_s and hit_port) |-> apb_rsp.prdata[31:PW] == '0)
    else $error("port reset reserved bits not zero");

  raw_ro_a: assert property ( // [R4]
    (wr_en && hit_raw && evt_vec == '0) |=> raw_q == $past(raw_q))
    else $error("raw status changed by software write");

  evt_set_a: assert property ( // [R5] [R6] [R7] [R8] [R9] [R11]
    evt_vec != '0 |=> (raw_q & $past(evt_vec)) == $past(evt_vec))
    else $error("event did not set its raw bit");

  bor_raw_a: assert property ( // [R10]
    evt_vec[SCI_EVT_BROWNOUT] && st_q.bor_sel
      |=> raw_q[SCI_EVT_BROWNOUT])
    else $error("brown-out not recorded while routed to reset");

  rsvd_zero_a: assert property ( // [R12]
    (read_acc_s and (hit_raw || hit_mask || hit_mstat))
      |-> apb_rsp.prdata[31:NE] == '0)
    else $error("status or mask reserved bits not zero");

  mask_wr_a: assert property ( // [R13]
    mask_wr_s ##1 (!wr_en || !hit_mask) [*2]
      |-> st_q.mask == $past(apb_req.pwdata[NE-1:0], 2))
    else $error("mask write not stored");

  lock_irq_a: assert property ( // [R14]
    (st_q.mask[SCI_EVT_PLL_LOCK] && evt_vec[SCI_EVT_PLL_LOCK]
      && !raw_clr[SCI_EVT_PLL_LOCK] && !(wr_en && hit_mask))
      |=> ##1 irq)
    else $error("pll lock did not raise irq");

  bor_irq_a: assert property ( // [R15] [R17]
    (st_q.bor_sel && raw_q == (1 << SCI_EVT_BROWNOUT)) |=> !irq)
    else $error("brown-out raised irq while routed to reset");

  fault_irq_a: assert property ( // [R16]
    (st_q.mask == '0) [*2] |-> !irq)
    else $error("irq raised with all masks clear");

  bor_rst_a: assert property ( // [R17]
    evt_vec[SCI_EVT_BROWNOUT] && st_q.bor_sel |=> brownout_reset_req)
    else $error("brown-out reset not signalled");

  mstat_clr_a: assert property ( // [R18]
    (mstat_wr_s and (raw_clr != '0) and (evt_vec == '0))
      |=> (raw_q & $past(raw_clr)) == '0)
    else $error("masked clear did not clear raw bit");

  irq_level_a: assert property ( // [R19]
    (irq_src != '0) |=> irq)
    else $error("irq not raised for pending masked event");

  port_hold_a: assert property ( // [R20]
    !(wr_en && hit_port) |=> $stable(port_reset))
    else $error("port reset changed without a write");

  bor_irq_on_a: assert property ( // [R15]
    (st_q.mask[SCI_EVT_BROWNOUT] && raw_q[SCI_EVT_BROWNOUT]
      && !st_q.bor_sel) |=> irq)
    else $error("brown-out did not raise irq");

  fault_irq_on_a: assert property ( // [R16]
    (st_q.mask[SCI_EVT_PLL_FAULT] && raw_q[SCI_EVT_PLL_FAULT]) |=> irq)
    else $error("pll fault did not raise irq");

  irq_quiet_a: assert property ( // [R19]
    (irq_src == '0) |=> !irq)
    else $error("irq raised with no masked event pending");

  mstat_read_a: assert property ( // [R18]
    (read_acc_s and hit_mstat)
      |-> apb_rsp.prdata[NE-1:0] == $past(raw_q & st_q.mask))
    else $error("masked status read wrong");

endmodule

// >>> testbench/sci_irq_sink.sv
`timescale 1ns/1ns
module sci_irq_sink (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq,
  output logic [7:0]      irq_cnt_q
);
  logic       irq_q;
  logic [7:0] irq_cnt_d;
  // level input: core enters once per rising level, so count edges
  assign irq_cnt_d = irq_cnt_q + {7'h00, irq & ~irq_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q     <= 1'b0;
      irq_cnt_q <= 8'h00;
    end else begin
      irq_q     <= irq;
      irq_cnt_q <= irq_cnt_d;
    end
  end
endmodule

// >>> testbench/sci_top_tb_top.sv
`timescale 1ns/1ns
module sci_top_tb_top;
  import sci_pkg::*;
  logic         pclk;
  logic         presetn;
  sci_apb_req_s apb_req;
  sci_apb_rsp_s apb_rsp;
  sci_evt_s     evt_in;
  logic [4:0]   caps;
  logic [4:0]   port_reset;
  logic         irq;
  logic         bor_req;
  logic [7:0]   irq_cnt;
  logic [31:0]  rd;
  logic         err;
  int           errors;
  int           compares;

  sci_top dut (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .apb_req                   (apb_req),
    .apb_rsp                   (apb_rsp),
    .evt_in                    (evt_in),
    .device_capabilities_ports (caps),
    .port_reset                (port_reset),
    .irq                       (irq),
    .brownout_reset_req        (bor_req)
  );

  sci_irq_sink core (
    .pclk      (pclk),
    .presetn   (presetn),
    .irq       (irq),
    .irq_cnt_q (irq_cnt)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task finish_test;
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; one idle cycle follows each transfer
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      finish_test;
    end
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask

  task t_reset;
    rchk(SCI_OFF_PORT_RST, 32'h00000000);
    rchk(SCI_OFF_RAW, 32'h00000000);
    rchk(SCI_OFF_MASK, 32'h00000000);
    chk({27'h0, port_reset}, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
  endtask

  task t_ports;
    caps <= 5'h15;
    apb(1'b1, SCI_OFF_PORT_RST, 32'hFFFFFFFF);
    rchk(SCI_OFF_PORT_RST, 32'h00000015);
    chk({27'h0, port_reset}, 32'h00000015);
    rchk(SCI_OFF_CAPS, 32'h00000015);
    // gate also protects set bits from being cleared
    caps <= 5'h0A;
    apb(1'b1, SCI_OFF_PORT_RST, 32'h00000000);
    rchk(SCI_OFF_PORT_RST, 32'h00000015);
    caps <= 5'h1F;
    apb(1'b1, SCI_OFF_PORT_RST, 32'h0000000A);
    rchk(SCI_OFF_PORT_RST, 32'h0000000A);
    apb(1'b1, SCI_OFF_PORT_RST, 32'h00000000);
    chk({27'h0, port_reset}, 32'h00000000);
  endtask

  task t_strobe;
    apb_req.pstrb <= 4'hE;
    apb(1'b1, SCI_OFF_MASK, 32'h0000007F);
    apb_req.pstrb <= 4'hF;
    rchk(SCI_OFF_MASK, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
  endtask

  task t_events;
    for (int i = 0; i < 7; i++) begin
      evt_in <= sci_evt_s'(7'h01 << i);
      @(posedge pclk);
      evt_in <= sci_evt_s'(7'h00);
      apb(1'b1, SCI_OFF_RAW, 32'hFFFFFFFF);
      rchk(SCI_OFF_RAW, 32'h1 << i);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, SCI_OFF_MASK, 32'hFFFFFF80 | (32'h1 << i));
      rchk(SCI_OFF_MASK, 32'h1 << i);
      chk({31'h0, irq}, 32'h1);
      rchk(SCI_OFF_MSTAT, 32'h1 << i);
      apb(1'b1, SCI_OFF_MSTAT, 32'h1 << i);
      rchk(SCI_OFF_RAW, 32'h00000000);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, SCI_OFF_MASK, 32'h00000000);
    end
    chk({24'h0, irq_cnt}, 32'h7);
  endtask

  task t_brownout;
    apb(1'b1, SCI_OFF_BORCTL, 32'h00000002);
    rchk(SCI_OFF_BORCTL, 32'h00000002);
    apb(1'b1, SCI_OFF_MASK, 32'h00000002);
    evt_in <= sci_evt_s'(7'h02);
    repeat (2) @(posedge pclk);
    chk({31'h0, bor_req}, 32'h1);
    evt_in <= sci_evt_s'(7'h00);
    repeat (2) @(posedge pclk);
    chk({31'h0, bor_req}, 32'h0);
    rchk(SCI_OFF_RAW, 32'h00000002);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, SCI_OFF_MSTAT, 32'h00000002);
    apb(1'b1, SCI_OFF_BORCTL, 32'h00000000);
    apb(1'b1, SCI_OFF_MASK, 32'h00000000);
    chk({24'h0, irq_cnt}, 32'h7);
  endtask

  task t_unmapped;
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1);
    rchk(12'h100, 32'h00000000);
    chk({31'h0, err}, 32'h1);
  endtask

  initial begin
    errors   = 0;
    compares = 0;
    presetn  = 1'b0;
    apb_req  = '0;
    apb_req.pstrb = 4'hF;
    evt_in   = sci_evt_s'(7'h00);
    caps     = 5'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_ports;
    t_strobe;
    t_events;
    t_brownout;
    t_unmapped;
    finish_test;
  end

  // run needs well under 1000 cycles
  initial begin
    #80000;
    errors++;
    finish_test;
  end
endmodule
